/* eag_pkg.sv */
// effective address generator constants and shared types
// assumes one clock domain; decoder supplies extension word fields already split out
package eag_pkg;
    localparam int          EAG_AW       = 32;
    localparam int          EAG_NREG     = 16;
    localparam logic [2:0]  EAG_IIS_NONE = 3'h0;
    localparam logic [2:0]  EAG_IIS_RSVD = 3'h4;
    localparam logic [2:0]  EAG_IIS_POST = 3'h4;
    localparam logic [1:0]  EAG_OD_NULL  = 2'h1;
    localparam logic [1:0]  EAG_OD_WORD  = 2'h2;
    localparam logic [1:0]  EAG_BD_RSVD  = 2'h0;
    localparam logic [31:0] EAG_RST_ADDR = 32'h0000_0000;
    localparam int          EAG_CALC_CYC = 1;

    typedef enum logic [1:0] {
        EAG_MODE_INDEX,
        EAG_MODE_POSTINC,
        EAG_MODE_PREDEC
    } eag_mode_e;

    function automatic logic [31:0] eag_sext16(input logic [15:0] w);
        eag_sext16 = {{16{w[15]}}, w};
    endfunction : eag_sext16
endpackage : eag_pkg

/* eag_index_unit.sv */
// sizes and scales the selected index register
// assumes register file contents are presented as a flat 16 x 32 vector
`timescale 1ns/1ps
module eag_index_unit (
    // register file and selection
    input  wire logic [511:0] reg_file,
    input  wire logic [3:0]   index_register,
    input  wire logic         index_long,
    input  wire logic [1:0]   index_scale,
    input  wire logic         index_suppress_bit,
    // result
    output logic      [31:0]  scaled_index
);
    logic [31:0] raw;
    logic [31:0] sized;

    always_comb begin
        raw = reg_file[index_register*32 +: 32];
        sized = index_long ? raw : eag_pkg::eag_sext16(raw[15:0]);
        // pure shift, same cycle, copy only
        scaled_index = index_suppress_bit ? 32'h0 : (sized << index_scale);
    end
endmodule : eag_index_unit

/* eag_effective_address_generator.sv */
// effective address datapath with one memory indirect pointer fetch
// assumes decoder holds inputs stable from start until done; memory answers with mem_ack
`timescale 1ns/1ps
module eag_effective_address_generator (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // request from decoder
    input  wire logic        start,
    input  wire logic [1:0]  mode,
    input  wire logic [2:0]  pointer_register,
    input  wire logic        pc_relative,
    input  wire logic        zero_program_counter,
    input  wire logic [31:0] program_counter,
    input  wire logic        base_suppress_bit,
    input  wire logic        index_suppress_bit,
    input  wire logic [3:0]  index_register,
    input  wire logic        index_long,
    input  wire logic [1:0]  index_scale,
    input  wire logic [2:0]  indirection_select_field,
    input  wire logic [1:0]  bd_size,
    input  wire logic [31:0] base_displacement,
    input  wire logic [31:0] outer_displacement,
    input  wire logic [2:0]  step_size,
    input  wire logic [511:0] reg_file,
    // pointer fetch port
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    output logic             mem_prog_space,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // result
    output logic             busy,
    output logic             done,
    output logic [31:0]      ea,
    output logic             ea_prog_space,
    output logic             bad_encoding,
    output logic             reg_wr,
    output logic [2:0]       reg_wr_sel,
    output logic [31:0]      reg_wr_data
);
    typedef enum logic [1:0] {EAG_IDLE, EAG_FETCH, EAG_DONE} eag_st_e;

    eag_st_e     st_q, st_d;
    logic [31:0] ea_q, ea_d, maddr_q, maddr_d, wrd_q, wrd_d;
    logic        ps_q, ps_d, done_q, done_d, bad_q, bad_d, wr_q, wr_d;
    logic [2:0]  sel_q, sel_d;
    logic [31:0] sidx, base_val, bd_val, od_val, an_val, inter;
    logic        indirect, post, rsvd;

    eag_index_unit eag_index_unit_inst (
        .reg_file           (reg_file),
        .index_register     (index_register),
        .index_long         (index_long),
        .index_scale        (index_scale),
        .index_suppress_bit (index_suppress_bit),
        .scaled_index       (sidx)
    );

    always_comb begin
        an_val = reg_file[(5'd8 + {2'b00, pointer_register})*32 +: 32];
        if (base_suppress_bit)
            base_val = 32'h0;
        else if (pc_relative)
            base_val = zero_program_counter ? 32'h0 : program_counter;
        else
            base_val = an_val;
        bd_val = (bd_size == eag_pkg::EAG_OD_NULL || bd_size == eag_pkg::EAG_BD_RSVD) ? 32'h0
               : base_displacement;
        indirect = indirection_select_field != eag_pkg::EAG_IIS_NONE;
        post     = !index_suppress_bit && indirection_select_field[2];
        rsvd     = (bd_size == eag_pkg::EAG_BD_RSVD)
                 || (indirection_select_field == eag_pkg::EAG_IIS_RSVD)
                 || (index_suppress_bit && indirection_select_field[2]);
        od_val   = (indirection_select_field[1:0] == eag_pkg::EAG_OD_NULL) ? 32'h0 : outer_displacement;
        // index only before fetch when not post
        inter = post ? (base_val + bd_val) : (base_val + bd_val + sidx);
    end

    always_comb begin
        st_d    = st_q;
        ea_d    = ea_q;
        maddr_d = maddr_q;
        ps_d    = ps_q;
        done_d  = 1'b0;
        bad_d   = bad_q;
        wr_d    = 1'b0;
        wrd_d   = wrd_q;
        sel_d   = sel_q;
        case (st_q)
            EAG_IDLE: if (start) begin
                ps_d  = pc_relative && mode == 2'(eag_pkg::EAG_MODE_INDEX);
                bad_d = 1'b0;
                sel_d = pointer_register;
                if (mode == 2'(eag_pkg::EAG_MODE_POSTINC)) begin
                    ea_d  = an_val;
                    wr_d  = 1'b1;
                    wrd_d = an_val + {29'h0, step_size};
                    st_d  = EAG_DONE;
                end else if (mode == 2'(eag_pkg::EAG_MODE_PREDEC)) begin
                    ea_d  = an_val - {29'h0, step_size};
                    wr_d  = 1'b1;
                    wrd_d = an_val - {29'h0, step_size};
                    st_d  = EAG_DONE;
                end else if (rsvd) begin
                    bad_d = 1'b1;
                    ea_d  = inter;
                    st_d  = EAG_DONE;
                end else if (indirect) begin
                    maddr_d = inter;
                    st_d    = EAG_FETCH;
                end else begin
                    ea_d = inter;
                    st_d = EAG_DONE;
                end
            end
            EAG_FETCH: if (mem_ack) begin
                ea_d = mem_rdata + od_val + (post ? sidx : 32'h0);
                // pointer based result
                // final address is not pc relative, so it goes to data space
                ps_d = 1'b0;
                st_d = EAG_DONE;
            end
            default: begin
                done_d = 1'b1;
                st_d   = EAG_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q    <= EAG_IDLE;
            ea_q    <= eag_pkg::EAG_RST_ADDR;
            maddr_q <= eag_pkg::EAG_RST_ADDR;
            ps_q    <= 1'b0;
            done_q  <= 1'b0;
            bad_q   <= 1'b0;
            wr_q    <= 1'b0;
            wrd_q   <= 32'h0;
            sel_q   <= 3'h0;
        end else begin
            st_q    <= st_d;
            ea_q    <= ea_d;
            maddr_q <= maddr_d;
            ps_q    <= ps_d;
            done_q  <= done_d;
            bad_q   <= bad_d;
            wr_q    <= wr_d;
            wrd_q   <= wrd_d;
            sel_q   <= sel_d;
        end
    end

    assign mem_req        = st_q == EAG_FETCH;
    assign mem_addr       = maddr_q;
    assign mem_prog_space = ps_q;
    assign busy           = st_q != EAG_IDLE;
    assign done           = done_q;
    assign ea             = ea_q;
    assign ea_prog_space  = ps_q;
    assign bad_encoding   = bad_q;
    assign reg_wr         = wr_q;
    assign reg_wr_sel     = sel_q;
    assign reg_wr_data    = wrd_q;

    property p_direct_time;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && !indirect && mode == 2'(eag_pkg::EAG_MODE_INDEX)) |-> ##2 done;
    endproperty
    a_direct_time: assert property (p_direct_time) else $error("direct ea not done in two cycles");
    property p_direct_sum;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && !indirect && !rsvd && mode == 2'(eag_pkg::EAG_MODE_INDEX))
        |=> ea == $past(base_val) + $past(bd_val) + $past(sidx);
    endproperty
    a_direct_sum: assert property (p_direct_sum) else $error("direct ea sum wrong");
    property p_bs;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && base_suppress_bit && !indirect && mode == 2'(eag_pkg::EAG_MODE_INDEX))
        |=> ea == $past(bd_val) + $past(sidx);
    endproperty
    a_bs: assert property (p_bs) else $error("base not suppressed");
    property p_fetch_addr;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && indirect && !rsvd && mode == 2'(eag_pkg::EAG_MODE_INDEX))
        |=> mem_req && mem_addr == $past(inter);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("pointer fetch address wrong");
    property p_final;
        @(posedge sys_clk) disable iff (!nrst)
        (mem_req && mem_ack) |=> ##1 done
        && ea == $past(mem_rdata, 2) + $past(od_val, 2) + ($past(post, 2) ? $past(sidx, 2) : 32'h0);
    endproperty
    a_final: assert property (p_final) else $error("final ea after fetch wrong");
    property p_space;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && mode == 2'(eag_pkg::EAG_MODE_INDEX)) |=> ea_prog_space == $past(pc_relative);
    endproperty
    a_space: assert property (p_space) else $error("address space wrong");
    property p_final_space;
        @(posedge sys_clk) disable iff (!nrst)
        (mem_req && mem_ack) |=> !ea_prog_space;
    endproperty
    a_final_space: assert property (p_final_space) else $error("pointer result not in data space");
    property p_zpc;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && pc_relative && zero_program_counter && !indirect
         && mode == 2'(eag_pkg::EAG_MODE_INDEX))
        |=> ea_prog_space && ea == $past(bd_val) + $past(sidx);
    endproperty
    a_zpc: assert property (p_zpc) else $error("suppressed pc contributed");
    property p_postinc;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && mode == 2'(eag_pkg::EAG_MODE_POSTINC))
        |=> reg_wr && ea == $past(an_val) && reg_wr_data == $past(an_val) + {29'h0, $past(step_size)};
    endproperty
    a_postinc: assert property (p_postinc) else $error("post-increment wrong");
    property p_predec;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && mode == 2'(eag_pkg::EAG_MODE_PREDEC))
        |=> reg_wr && ea == reg_wr_data && ea == $past(an_val) - {29'h0, $past(step_size)};
    endproperty
    a_predec: assert property (p_predec) else $error("pre-decrement wrong");
    property p_is;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == EAG_IDLE && start && index_suppress_bit && !indirect && mode == 2'(eag_pkg::EAG_MODE_INDEX))
        |=> ea == $past(base_val) + $past(bd_val);
    endproperty
    a_is: assert property (p_is) else $error("suppressed index contributed");
    c_fetch: cover property (@(posedge sys_clk) disable iff (!nrst) mem_req && mem_ack);
    c_post: cover property (@(posedge sys_clk) disable iff (!nrst) mem_req && mem_ack && post);
    c_bad: cover property (@(posedge sys_clk) disable iff (!nrst) done && bad_encoding);
    c_zpc: cover property (@(posedge sys_clk) disable iff (!nrst) start && pc_relative && zero_program_counter);
endmodule : eag_effective_address_generator

/* eag_mem_model.sv */
// pointer memory model for the indirect fetch port
// assumes mem_req holds until the ack edge; wait_cyc sets wait states
`timescale 1ns/1ps
module eag_mem_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // fetch port
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [2:0]  wait_cyc,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    logic [2:0] cnt_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q     <= 3'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack && cnt_q == wait_cyc) begin
            mem_ack   <= 1'b1;
            mem_rdata <= {mem_addr[15:0], mem_addr[31:16]} ^ 32'h9e37_79b9;
        end else begin
            // data not held outside the ack cycle
            cnt_q     <= (mem_req && !mem_ack) ? cnt_q + 3'h1 : 3'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : eag_mem_model

/* eag_effective_address_generator_bench.sv */
// self-checking bench for the effective address generator
// assumes one 20 MHz clock; memory model answers fetches
`timescale 1ns/1ps
module eag_effective_address_generator_bench;
    logic         sys_clk, nrst, start, pc_relative, zero_program_counter, mem_ack;
    logic         base_suppress_bit, index_suppress_bit, index_long, mem_req, mem_prog_space;
    logic         busy, done, ea_prog_space, bad_encoding, reg_wr;
    logic [1:0]   mode, index_scale, bd_size;
    logic [2:0]   pointer_register, indirection_select_field, step_size, wait_cyc, reg_wr_sel;
    logic [3:0]   index_register;
    logic [31:0]  program_counter, base_displacement, outer_displacement, mem_addr, mem_rdata;
    logic [31:0]  ea, reg_wr_data, lfsr;
    logic [511:0] reg_file;
    int           mismatches, checked;

    eag_effective_address_generator eag_effective_address_generator_inst (
        .sys_clk                  (sys_clk),
        .nrst                     (nrst),
        .start                    (start),
        .mode                     (mode),
        .pointer_register         (pointer_register),
        .pc_relative              (pc_relative),
        .zero_program_counter     (zero_program_counter),
        .program_counter          (program_counter),
        .base_suppress_bit        (base_suppress_bit),
        .index_suppress_bit       (index_suppress_bit),
        .index_register           (index_register),
        .index_long               (index_long),
        .index_scale              (index_scale),
        .indirection_select_field (indirection_select_field),
        .bd_size                  (bd_size),
        .base_displacement        (base_displacement),
        .outer_displacement       (outer_displacement),
        .step_size                (step_size),
        .reg_file                 (reg_file),
        .mem_req                  (mem_req),
        .mem_addr                 (mem_addr),
        .mem_prog_space           (mem_prog_space),
        .mem_ack                  (mem_ack),
        .mem_rdata                (mem_rdata),
        .busy                     (busy),
        .done                     (done),
        .ea                       (ea),
        .ea_prog_space            (ea_prog_space),
        .bad_encoding             (bad_encoding),
        .reg_wr                   (reg_wr),
        .reg_wr_sel               (reg_wr_sel),
        .reg_wr_data              (reg_wr_data)
    );
    eag_mem_model eag_mem_model_inst (.sys_clk(sys_clk), .nrst(nrst), .mem_req(mem_req), .mem_addr(mem_addr),
        .wait_cyc(wait_cyc), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        nxt = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction : nxt

    function automatic logic [31:0] r32();
        lfsr = nxt(lfsr);
        r32 = lfsr;
    endfunction : r32

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (exp !== got) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic rnd();
        logic [31:0] r;
        for (int i = 0; i < 16; i++) reg_file[i*32 +: 32] = r32();
        r = r32();
        mode = r[1:0] == 2'h3 ? 2'h0 : r[1:0];
        {pointer_register, pc_relative, zero_program_counter, base_suppress_bit} = r[7:2];
        {index_suppress_bit, index_register, index_long, index_scale} = r[15:8];
        {indirection_select_field, bd_size, step_size, wait_cyc} = r[26:16];
        program_counter = r32();
        base_displacement = r32();
        outer_displacement = r32();
    endtask : rnd

    task automatic run();
        logic [31:0] b, x, ir, an, inter, e, wd, sa, swd;
        logic [2:0]  sel, ssel;
        logic        bad, fetch, sf, sp, sw, sb, eps;
        int          n;
        sel = indirection_select_field;
        ir = reg_file[index_register*32 +: 32];
        an = reg_file[(8+pointer_register)*32 +: 32];
        x = index_suppress_bit ? 32'h0 : (index_long ? ir : {{16{ir[15]}}, ir[15:0]}) << index_scale;
        b = base_suppress_bit ? 32'h0 : pc_relative ? (zero_program_counter ? 32'h0 : program_counter) : an;
        // reserved and null base displacement both add nothing
        b = b + (bd_size[1] ? base_displacement : 32'h0);
        bad = mode == 2'h0 && (bd_size == 2'h0 || (sel[2] && (index_suppress_bit || sel[1:0] == 2'h0)));
        fetch = !bad && mode == 2'h0 && sel != 3'h0;
        inter = b + (sel[2] ? 32'h0 : x);
        e = fetch ? ({inter[15:0], inter[31:16]} ^ 32'h9e37_79b9) + (sel[2] ? x : 32'h0)
            + (sel[1:0] == 2'h1 ? 32'h0 : outer_displacement) : inter;
        wd = mode == 2'h1 ? an + step_size : an - step_size;
        if (mode != 2'h0) e = mode == 2'h1 ? an : wd;
        eps = mode == 2'h0 && pc_relative && !fetch;
        @(negedge sys_clk);
        start = 1'b1;
        {n, sf, sp, sw, sb, sa, swd, ssel} = '0;
        while (n < 40 && done !== 1'b1) begin
            @(negedge sys_clk);
            start = 1'b0;
            n++;
            if (n == 1) sb = busy;
            if (mem_req === 1'b1 && !sf) {sf, sa, sp} = {1'b1, mem_addr, mem_prog_space};
            if (reg_wr === 1'b1) {sw, swd, ssel} = {1'b1, reg_wr_data, reg_wr_sel};
        end
        chk("done", 32'h1, {31'h0, done});
        chk("busy_run", 32'h1, {31'h0, sb});
        chk("busy_end", 32'h0, {31'h0, busy});
        chk("ea", e, ea);
        chk("bad_encoding", {31'h0, bad}, {31'h0, bad_encoding});
        chk("fetch", {31'h0, fetch}, {31'h0, sf});
        if (fetch) chk("mem_addr", inter, sa);
        if (fetch) chk("mem_prog_space", {31'h0, pc_relative}, {31'h0, sp});
        // fetch: take, ack seen after wait_cyc plus two edges, then done two edges later
        chk("latency", fetch ? 32'h4 + {29'h0, wait_cyc} : 32'h2, n);
        if (!bad) chk("ea_prog_space", {31'h0, eps}, {31'h0, ea_prog_space});
        chk("reg_wr", {31'h0, mode != 2'h0}, {31'h0, sw});
        if (mode != 2'h0) chk("reg_wr_data", wd, swd);
        if (mode != 2'h0) chk("reg_wr_sel", {29'h0, pointer_register}, {29'h0, ssel});
    endtask : run

    initial begin
        {mismatches, checked, start, nrst} = '0;
        lfsr = 32'h41f6_6ff9;
        rnd();
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        // every index suppress, select and scale code with wrapping sums
        for (int k = 0; k < 64; k++) begin
            rnd();
            {index_suppress_bit, indirection_select_field, index_scale} = k[5:0];
            {mode, bd_size, base_displacement} = {2'h0, 2'h3, 32'hffff_fff0};
            run();
        end
        $display("corner test done, %0d mismatches", mismatches);
        for (int k = 0; k < 300; k++) begin
            rnd();
            run();
        end
        $display("random test done, %0d mismatches", mismatches);
        stop_test();
    end

    initial begin
        #1_000_000;
        mismatches++;
        stop_test();
    end
endmodule : eag_effective_address_generator_bench
